//--- fcp_defs.vh
// constants of the flash config and protect block
`ifndef FCP_DEFS_VH
`define FCP_DEFS_VH

// register indices, byte address is four times the index
`define FCP_IDX_CONFIG 4'h3
`define FCP_IDX_PROTECT 4'h4
`define FCP_BYTE_OFS 2'h0

// configuration register fields
`define FCP_CFG_BEIE 7
`define FCP_CFG_CMD_DONE_IRQ_EN 6
`define FCP_CFG_KEY 5
`define FCP_CFG_RST 8'h00

// protection register fields
`define FCP_PR_POL 7
`define FCP_PR_NV 6
`define FCP_PR_HDIS 5
`define FCP_PR_HS_HI 4
`define FCP_PR_HS_LO 3
`define FCP_PR_LDIS 2
`define FCP_PR_LS_HI 1
`define FCP_PR_LS_LO 0
`define FCP_PROT_RST 8'hff

// security register backdoor key enable field
`define FCP_BACKDOOR_KEY_ENABLE_HI 7
`define FCP_BACKDOOR_KEY_ENABLE_LO 6
`define FCP_BACKDOOR_KEY_ENABLE_ON 2'h2

// flash map of the sized ranges
`define FCP_LO_BASE 16'h4000
`define FCP_LO_UNIT 16'h0400
`define FCP_HI_BASE 16'hc000
`define FCP_HI_UNIT 16'h0800
`define FCP_MID_ADDR 16'h8000
`define FCP_SAMPLES 8
`define FCP_ONE 16'h0001

`endif

//--- fcp_prot_check.v
// program and erase admission check against the active protection byte
`include "fcp_defs.vh"

module fcp_prot_check
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // active protection byte
    input wire [7:0] i_prot_cfg,
    // operation request
    input wire i_op_valid,
    input wire [15:0] i_op_addr,
    input wire i_op_mass_erase,
    // verdict, one cycle pulses
    output wire o_op_allowed,
    output wire o_protect_violation
);

////////////////////////////////////////////////////////////////////////////

// 1 when addr may not be programmed or erased under protection byte cfg
function fcp_prot_at;
    input [7:0] cfg;
    input [15:0] addr;
    reg [15:0] hi_start;
    reg [15:0] lo_end;
    reg in_hi;
    reg in_lo;
    reg ranged;
    begin
        hi_start = ~((`FCP_HI_UNIT << cfg[`FCP_PR_HS_HI:`FCP_PR_HS_LO])
            - `FCP_ONE);
        lo_end = `FCP_LO_BASE
            + (`FCP_LO_UNIT << cfg[`FCP_PR_LS_HI:`FCP_PR_LS_LO]) - `FCP_ONE;
        in_hi = (addr >= hi_start) && !cfg[`FCP_PR_HDIS];
        in_lo = (addr >= `FCP_LO_BASE) && (addr <= lo_end)
            && !cfg[`FCP_PR_LDIS];
        ranged = in_hi || in_lo;
        if (cfg[`FCP_PR_POL])
            fcp_prot_at = ranged;
        else
            fcp_prot_at = !ranged;
    end
endfunction

reg allowed_reg;
reg allowed_next;
reg viol_reg;
reg viol_next;
reg full_open;

always @*
begin
    allowed_next = 1'b0;
    viol_next = 1'b0;
    full_open = i_prot_cfg[`FCP_PR_POL] && i_prot_cfg[`FCP_PR_HDIS]
        && i_prot_cfg[`FCP_PR_LDIS];
    if (i_op_valid)
    begin
        if (i_op_mass_erase)
        begin
            // mass erase only with protection fully open
            allowed_next = full_open;
            viol_next = !full_open;
        end
        else
        begin
            // a protected target is refused and flagged
            allowed_next = !fcp_prot_at(i_prot_cfg, i_op_addr);
            viol_next = fcp_prot_at(i_prot_cfg, i_op_addr);
        end
    end
end

always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        allowed_reg <= 1'b0;
        viol_reg <= 1'b0;
    end
    else
    begin
        allowed_reg <= allowed_next;
        viol_reg <= viol_next;
    end
end

assign o_op_allowed = allowed_reg;
assign o_protect_violation = viol_reg;

endmodule

//--- fcp_flash_cfg_prot.v
// flash configuration and protection registers with avalon-mm slave
//
// Local design decision: register access over Avalon-MM.
`include "fcp_defs.vh"

// Function
// - config register: two irq enables and key gate read/write, rest zero
// - key gate writable only while backdoor key enable shows enabled
// - backdoor key enable counts as enabled only for encoding 10
// - buffer-empty irq requested while its enable and flag are both set
// - command-done irq requested while its enable and flag are both set
// - gate 0: array write starts command; gate 1: key word, reads invalid
// - protection register readable in every operating mode
// - polarity bit may only be written from 1 to 0
// - low size field writable only while low disable bit is 1
// - high size field writable only while high disable bit is 1
// - whole protection register loaded from nonvolatile byte at reset
// - program or erase of protected area refused, violation flagged
// - mass erase only with polarity and both disable bits set
// - polarity selects protected or unprotected meaning of ranges
// - high disable 0 creates the sized range at top of map
// - low disable 0 creates the sized range in lower map
// - high size selects 2, 4, 8 or 16 Kbytes ending at ffff
// - low size selects 1, 2, 4 or 8 Kbytes from 4000
// - write leading to a disallowed scenario is ignored entirely
module fcp_flash_cfg_prot
#(
    parameter ADDR_W = 6
)
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // avalon-mm slave
    input wire [ADDR_W-1:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output wire [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // reset sequence load of the protection byte
    input wire i_nv_load,
    input wire [7:0] i_nv_protect_byte,
    // security register contents
    input wire [7:0] i_security_reg,
    // command controller flags
    input wire i_buf_empty_flag,
    input wire i_cmd_done_flag,
    // interrupt requests
    output wire o_buf_empty_irq,
    output wire o_cmd_done_irq,
    // flash array access steering
    input wire i_array_write,
    input wire i_array_read,
    output wire o_cmd_write_start,
    output wire o_key_word_write,
    output wire o_array_read_invalid,
    output wire o_key_write_gate,
    // program and erase admission
    input wire i_op_valid,
    input wire [15:0] i_op_addr,
    input wire i_op_mass_erase,
    output wire o_op_allowed,
    output wire o_protect_violation,
    // active protection byte for the rest of the controller
    output wire [7:0] o_protect_cfg
);

////////////////////////////////////////////////////////////////////////////
// transition check: protection may be added, never removed

// 1 when addr may not be programmed or erased under protection byte cfg
function fcp_prot_at;
    input [7:0] cfg;
    input [15:0] addr;
    reg [15:0] hi_start;
    reg [15:0] lo_end;
    reg in_hi;
    reg in_lo;
    reg ranged;
    begin
        // 00:f800 01:f000 10:e000 11:c000, all ending at ffff
        hi_start = ~((`FCP_HI_UNIT << cfg[`FCP_PR_HS_HI:`FCP_PR_HS_LO])
            - `FCP_ONE);
        // 00:43ff 01:47ff 10:4fff 11:5fff, all starting at 4000
        lo_end = `FCP_LO_BASE
            + (`FCP_LO_UNIT << cfg[`FCP_PR_LS_HI:`FCP_PR_LS_LO]) - `FCP_ONE;
        // a cleared disable bit makes its range exist
        in_hi = (addr >= hi_start) && !cfg[`FCP_PR_HDIS];
        in_lo = (addr >= `FCP_LO_BASE) && (addr <= lo_end)
            && !cfg[`FCP_PR_LDIS];
        ranged = in_hi || in_lo;
        // polarity swaps ranges between protected and unprotected
        if (cfg[`FCP_PR_POL])
            fcp_prot_at = ranged;
        else
            fcp_prot_at = !ranged;
    end
endfunction

// 1 when every address protected under old stays protected under new
function fcp_scn_legal;
    input [7:0] old_cfg;
    input [7:0] new_cfg;
    reg [15:0] lo_a;
    reg [15:0] hi_a;
    reg ok;
    integer k;
    begin
        ok = !fcp_prot_at(old_cfg, `FCP_MID_ADDR)
            || fcp_prot_at(new_cfg, `FCP_MID_ADDR);
        lo_a = `FCP_LO_BASE;
        hi_a = `FCP_HI_BASE;
        for (k = 0; k < `FCP_SAMPLES; k = k + 1)
        begin
            if (fcp_prot_at(old_cfg, lo_a) && !fcp_prot_at(new_cfg, lo_a))
                ok = 1'b0;
            if (fcp_prot_at(old_cfg, hi_a) && !fcp_prot_at(new_cfg, hi_a))
                ok = 1'b0;
            lo_a = lo_a + `FCP_LO_UNIT;
            hi_a = hi_a + `FCP_HI_UNIT;
        end
        fcp_scn_legal = ok;
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// bus slave handshake

reg wait_reg;
reg wait_next;
reg [31:0] rdata_reg;
reg [31:0] rdata_next;
wire bus_req;
wire bus_done;
wire [3:0] reg_idx;
wire lane_ok;
wire wr_cfg;
wire wr_prot;
wire [7:0] wbyte;

assign bus_req = i_avs_read || i_avs_write;
// the access completes at the edge where waitrequest is seen low
assign bus_done = bus_req && !wait_reg;
assign reg_idx = i_avs_address[ADDR_W-1:2];
assign lane_ok = (i_avs_address[1:0] == `FCP_BYTE_OFS);
assign wbyte = i_avs_writedata[7:0];
assign wr_cfg = bus_done && i_avs_write && lane_ok && i_avs_byteenable[0]
    && (reg_idx == `FCP_IDX_CONFIG);
assign wr_prot = bus_done && i_avs_write && lane_ok && i_avs_byteenable[0]
    && (reg_idx == `FCP_IDX_PROTECT);

// one wait cycle per access, then release for exactly one edge
always @*
begin
    wait_next = 1'b1;
    if (bus_req && wait_reg)
        wait_next = 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// configuration register

reg [7:0] cfg_reg;
reg [7:0] cfg_next;
wire backdoor_key_enable_on;

// only encoding 10 of the key enable field unlocks the gate
assign backdoor_key_enable_on = (i_security_reg[`FCP_BACKDOOR_KEY_ENABLE_HI:`FCP_BACKDOOR_KEY_ENABLE_LO]
    == `FCP_BACKDOOR_KEY_ENABLE_ON);

always @*
begin
    cfg_next = cfg_reg;
    if (wr_cfg)
    begin
        // enables are plain read/write bits
        cfg_next[`FCP_CFG_BEIE] = wbyte[`FCP_CFG_BEIE];
        cfg_next[`FCP_CFG_CMD_DONE_IRQ_EN] = wbyte[`FCP_CFG_CMD_DONE_IRQ_EN];
        // gate write dropped unless backdoor key access is enabled
        if (backdoor_key_enable_on)
            cfg_next[`FCP_CFG_KEY] = wbyte[`FCP_CFG_KEY];
    end
end

////////////////////////////////////////////////////////////////////////////
// protection register

reg [7:0] prot_reg;
reg [7:0] prot_next;
reg [7:0] prot_cand;

always @*
begin
    prot_cand = prot_reg;
    // polarity can only fall
    prot_cand[`FCP_PR_POL] = prot_reg[`FCP_PR_POL] && wbyte[`FCP_PR_POL];
    prot_cand[`FCP_PR_HDIS] = wbyte[`FCP_PR_HDIS];
    prot_cand[`FCP_PR_LDIS] = wbyte[`FCP_PR_LDIS];
    // high size frozen once its disable bit is cleared
    if (prot_reg[`FCP_PR_HDIS])
        prot_cand[`FCP_PR_HS_HI:`FCP_PR_HS_LO] =
            wbyte[`FCP_PR_HS_HI:`FCP_PR_HS_LO];
    // low size frozen once its disable bit is cleared
    if (prot_reg[`FCP_PR_LDIS])
        prot_cand[`FCP_PR_LS_HI:`FCP_PR_LS_LO] =
            wbyte[`FCP_PR_LS_HI:`FCP_PR_LS_LO];
    prot_next = prot_reg;
    if (i_nv_load)
        // reset sequence copies the nonvolatile byte unchecked
        prot_next = i_nv_protect_byte;
    else if (wr_prot && fcp_scn_legal(prot_reg, prot_cand))
        // a write removing protection leaves the register as it was
        prot_next = prot_cand;
end

////////////////////////////////////////////////////////////////////////////
// read mux

always @*
begin
    rdata_next = rdata_reg;
    if (bus_req && wait_reg)
    begin
        rdata_next = 32'h00000000;
        if (i_avs_read && lane_ok && (reg_idx == `FCP_IDX_CONFIG))
            // unimplemented positions read zero
            rdata_next[7:0] = cfg_reg;
        else if (i_avs_read && lane_ok && (reg_idx == `FCP_IDX_PROTECT))
            // readable regardless of operating mode
            rdata_next[7:0] = prot_reg;
    end
end

////////////////////////////////////////////////////////////////////////////
// interrupt requests and array access steering

reg be_irq_reg;
reg cd_irq_reg;
reg cmd_start_reg;
reg key_word_reg;
reg rd_inval_reg;
wire gate;

assign gate = cfg_reg[`FCP_CFG_KEY];

always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        be_irq_reg <= 1'b0;
        cd_irq_reg <= 1'b0;
        cmd_start_reg <= 1'b0;
        key_word_reg <= 1'b0;
        rd_inval_reg <= 1'b0;
    end
    else
    begin
        be_irq_reg <= cfg_reg[`FCP_CFG_BEIE] && i_buf_empty_flag;
        cd_irq_reg <= cfg_reg[`FCP_CFG_CMD_DONE_IRQ_EN] && i_cmd_done_flag;
        cmd_start_reg <= i_array_write && !gate;
        key_word_reg <= i_array_write && gate;
        rd_inval_reg <= i_array_read && gate;
    end
end

////////////////////////////////////////////////////////////////////////////
// state registers

always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        wait_reg <= 1'b1;
        rdata_reg <= 32'h00000000;
        cfg_reg <= `FCP_CFG_RST;
        prot_reg <= `FCP_PROT_RST;
    end
    else
    begin
        wait_reg <= wait_next;
        rdata_reg <= rdata_next;
        cfg_reg <= cfg_next;
        prot_reg <= prot_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// program and erase admission

fcp_prot_check u_check
(
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_prot_cfg(prot_reg),
    .i_op_valid(i_op_valid),
    .i_op_addr(i_op_addr),
    .i_op_mass_erase(i_op_mass_erase),
    .o_op_allowed(o_op_allowed),
    .o_protect_violation(o_protect_violation)
);

////////////////////////////////////////////////////////////////////////////
// outputs

assign o_avs_readdata = rdata_reg;
assign o_avs_waitrequest = wait_reg;
assign o_buf_empty_irq = be_irq_reg;
assign o_cmd_done_irq = cd_irq_reg;
assign o_cmd_write_start = cmd_start_reg;
assign o_key_word_write = key_word_reg;
assign o_array_read_invalid = rd_inval_reg;
assign o_key_write_gate = gate;
assign o_protect_cfg = prot_reg;

endmodule

//--- fcp_chk_asserts.sv
// concurrent checks on the ports of the flash config and protection block
module fcp_chk
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // register bus
    input wire i_avs_read,
    input wire i_avs_write,
    input wire o_avs_waitrequest,
    // protection, security and flags
    input wire i_nv_load,
    input wire [7:0] i_security_reg,
    input wire [7:0] o_protect_cfg,
    input wire i_buf_empty_flag,
    input wire i_cmd_done_flag,
    input wire o_buf_empty_irq,
    input wire o_cmd_done_irq,
    // array steering
    input wire i_array_write,
    input wire i_array_read,
    input wire o_cmd_write_start,
    input wire o_key_word_write,
    input wire o_array_read_invalid,
    input wire o_key_write_gate,
    // admission
    input wire i_op_valid,
    input wire i_op_mass_erase,
    input wire o_op_allowed,
    input wire o_protect_violation
);
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
////////////////////////////////////////////////////////////////////////////
sequence s_ans;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
endsequence
bus_answer_a:
    assert property ($rose(i_avs_read || i_avs_write) |=> s_ans)
    else $error("bus answer out of step");
gate_key_a:
    assert property ($rose(o_key_write_gate)
        |-> $past(i_security_reg[7:6]) == 2'h2)
    else $error("key gate set while key disabled");
be_irq_a:
    assert property (!i_buf_empty_flag |=> !o_buf_empty_irq)
    else $error("buffer empty irq without flag");
cd_irq_a:
    assert property (!i_cmd_done_flag |=> !o_cmd_done_irq)
    else $error("command done irq without flag");
steer_write_a:
    assert property (i_array_write |=>
        o_key_word_write == $past(o_key_write_gate) &&
        o_cmd_write_start == !$past(o_key_write_gate))
    else $error("array write steered wrongly");
read_inv_a:
    assert property (i_array_read && o_key_write_gate
        |=> o_array_read_invalid)
    else $error("array read not marked invalid");
pol_set_a:
    assert property ($rose(o_protect_cfg[7]) |-> $past(i_nv_load))
    else $error("polarity set by bus write");
lo_size_a:
    assert property (!$stable(o_protect_cfg[1:0])
        |-> $past(o_protect_cfg[2] || i_nv_load))
    else $error("low size changed while frozen");
hi_size_a:
    assert property (!$stable(o_protect_cfg[4:3])
        |-> $past(o_protect_cfg[5] || i_nv_load))
    else $error("high size changed while frozen");
verdict_one_a:
    assert property (1 |=> !(o_op_allowed && o_protect_violation) &&
        (o_op_allowed || o_protect_violation) == $past(i_op_valid))
    else $error("verdict pulse wrong");
mass_erase_a:
    assert property (i_op_valid && i_op_mass_erase |=>
        o_op_allowed == ($past(o_protect_cfg & 8'ha4) == 8'ha4))
    else $error("mass erase verdict wrong");
endmodule
bind fcp_flash_cfg_prot fcp_chk fcp_chk_i (.*);

//--- tb_top.sv
// self-checking bench of the flash config and protection block
module tb_top;
timeunit 1ns;
timeprecision 1ns;
logic i_clk = 0, i_rst = 1;
logic [5:0] i_avs_address = 0;
logic i_avs_read = 0, i_avs_write = 0;
logic [31:0] i_avs_writedata = 0;
logic [3:0] i_avs_byteenable = 4'h1;
logic i_nv_load = 0;
logic [7:0] i_nv_protect_byte = 0, i_security_reg = 8'h80;
logic i_buf_empty_flag = 0, i_cmd_done_flag = 0;
logic i_array_write = 0, i_array_read = 0;
logic i_op_valid = 0, i_op_mass_erase = 0;
logic [15:0] i_op_addr = 0;
wire [31:0] o_avs_readdata;
wire o_avs_waitrequest, o_buf_empty_irq, o_cmd_done_irq;
wire o_cmd_write_start, o_key_word_write, o_array_read_invalid;
wire o_key_write_gate, o_op_allowed, o_protect_violation;
wire [7:0] o_protect_cfg;
int n_fail = 0, num_checks = 0, i, k;
logic [7:0] q, d, c;
logic g;
logic [15:0] al [8];
logic [15:0] hs [4] = '{16'hf800, 16'hf000, 16'he000, 16'hc000};
logic [15:0] le [4] = '{16'h43ff, 16'h47ff, 16'h4fff, 16'h5fff};

fcp_flash_cfg_prot fcp_flash_cfg_prot_i (.*);

initial
begin
    forever #10 i_clk = ~i_clk;
end
////////////////////////////////////////////////////////////////////////////
task final_report;
begin
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
end
endtask

task chk(input logic [7:0] got, input logic [7:0] exp);
begin
    num_checks++;
    if (got !== exp)
    begin
        n_fail++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
end
endtask

task bus(input bit w, input logic [5:0] a, input logic [7:0] wd);
int n;
begin
    @(posedge i_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, wd};
    n = 0;
    do
    begin
        @(posedge i_clk);
        n++;
    end
    while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata[7:0];
    i_avs_read <= 0;
    i_avs_write <= 0;
    if (n >= 50)
    begin
        n_fail++;
        final_report;
    end
end
endtask

task rd(input logic [5:0] a, input logic [7:0] e);
begin
    bus(0, a, 8'h00);
    chk(q, e);
end
endtask

task nvl(input logic [7:0] b);
begin
    @(posedge i_clk);
    i_nv_load <= 1;
    i_nv_protect_byte <= b;
    @(posedge i_clk);
    i_nv_load <= 0;
end
endtask

task pw(input logic [7:0] w, input logic [7:0] e);
begin
    bus(1, 6'h10, w);
    rd(6'h10, e);
end
endtask

function logic prot(input logic [7:0] cf, input logic [15:0] a);
    logic r;
    r = (!cf[5] && a >= hs[cf[4:3]])
        || (!cf[2] && a >= 16'h4000 && a <= le[cf[1:0]]);
    return cf[7] ? r : !r;
endfunction

task op(input logic [15:0] a, input bit m, input logic [7:0] cf);
logic e;
begin
    @(posedge i_clk);
    i_op_valid <= 1;
    i_op_addr <= a;
    i_op_mass_erase <= m;
    e = m ? (cf[7] & cf[5] & cf[2]) : !prot(cf, a);
    @(posedge i_clk);
    i_op_valid <= 0;
    @(posedge i_clk);
    chk({6'h0, o_op_allowed, o_protect_violation}, {6'h0, e, !e});
end
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
    void'($urandom(41));
    repeat (5) @(posedge i_clk);
    i_rst <= 0;
    chk(o_protect_cfg, 8'hff);
    rd(6'h0c, 8'h00);
    rd(6'h10, 8'hff);
    d = $urandom;
    nvl(d);
    rd(6'h10, d);
    bus(1, 6'h14, 8'hff);
    rd(6'h14, 8'h00);
    rd(6'h0d, 8'h00);
    $display("test reset done");
    g = 0;
    for (k = 0; k < 12; k++)
    begin
        i_security_reg <= {k[1:0], 6'($urandom)};
        d = $urandom;
        bus(1, 6'h0c, d);
        g = (k % 4 == 2) ? d[5] : g;
        rd(6'h0c, {d[7:6], g, 5'h0});
        chk({7'h0, o_key_write_gate}, {7'h0, g});
    end
    $display("test config done");
    i_security_reg <= 8'h80;
    for (k = 0; k < 4; k++)
    begin
        bus(1, 6'h0c, {k[1:0], 6'h0});
        repeat (6)
        begin
            @(posedge i_clk);
            d = $urandom;
            i_buf_empty_flag <= d[1];
            i_cmd_done_flag <= d[0];
            repeat (2) @(posedge i_clk);
            chk({6'h0, o_buf_empty_irq, o_cmd_done_irq},
                {6'h0, d[1:0] & k[1:0]});
        end
        g = k[0];
        bus(1, 6'h0c, {2'h0, g, 5'h0});
        @(posedge i_clk);
        i_array_write <= 1;
        i_array_read <= 1;
        @(posedge i_clk);
        i_array_write <= 0;
        @(posedge i_clk);
        chk({5'h0, o_cmd_write_start, o_key_word_write,
            o_array_read_invalid}, {5'h0, !g, g, g});
        i_array_read <= 0;
    end
    $display("test irq and steering done");
    nvl(8'hff);
    pw(8'hfe, 8'hfe);
    pw(8'hfa, 8'hfa);
    pw(8'hf8, 8'hfa);
    pw(8'hfe, 8'hfa);
    pw(8'h7a, 8'hfa);
    nvl(8'h7f);
    pw(8'hff, 8'h7f);
    nvl(8'hff);
    pw(8'hc7, 8'hc7);
    pw(8'hd7, 8'hc7);
    pw(8'hdf, 8'hc7);
    $display("test protect writes done");
    nvl(8'hff);
    op(16'hff0d, 1'b0, 8'hff);
    nvl(8'hc7);
    op(16'hff0d, 1'b0, 8'hc7);
    for (i = 0; i < 40; i++)
    begin
        c = (i == 0) ? 8'hff : (i == 1) ? 8'h7f : 8'($urandom);
        nvl(c);
        al = '{hs[c[4:3]], hs[c[4:3]] - 16'h1, le[c[1:0]],
            le[c[1:0]] + 16'h1, 16'h4000, 16'h3fff, 16'($urandom),
            16'h8000};
        for (k = 0; k < 8; k++)
            op(al[k], 1'b0, c);
        op(16'($urandom), 1'b1, c);
    end
    $display("test admission done");
    final_report;
end
endmodule
